/* File: design/rcs_pkg.sv */
package rcs_pkg;
    // register offsets
    localparam logic [7:0] RCS_OFS_CTRL = 8'h01;
    localparam logic [7:0] RCS_OFS_FLAGS = 8'h02;
    localparam logic [7:0] RCS_OFS_IDENT = 8'h03;
    localparam logic [7:0] RCS_OFS_LVL_LO = 8'h04;
    localparam logic [7:0] RCS_OFS_LVL_HI = 8'h05;
    // serial target address
    localparam logic [6:0] RCS_TARGET_ADDR = 7'h75;
    // reset values
    localparam logic [6:0] RCS_CTRL_RST = 7'h00;
    localparam logic [6:0] RCS_LVL_LO_RST = 7'h33;
    localparam logic [6:0] RCS_LVL_HI_RST = 7'h39;
    // identity fields: maker value arbitrary, revisions arbitrary
    localparam logic [3:0] RCS_MAKER_CODE = 4'h5;
    localparam logic [1:0] RCS_REV_MAJOR = 2'h1;
    localparam logic [1:0] RCS_REV_MINOR = 2'h1;
    // control field positions
    localparam int RCS_CTRL_SLEW_LSB = 5;
    localparam int RCS_CTRL_QUIET_BIT = 4;
    localparam int RCS_CTRL_FFIX_BIT = 3;
    localparam int RCS_CTRL_RAMPFIX_BIT = 2;
    // ramp timing: one 25 mV code step at each ramp rate
    localparam int RCS_CLK_HZ = 20_000_000;
    localparam int RCS_STEP_UV = 25_000;
    localparam int RCS_RATE0_UV_PER_MS = 1_000_000;
    localparam int RCS_RATE1_UV_PER_MS = 2_500_000;
    localparam int RCS_RATE2_UV_PER_MS = 5_000_000;
    localparam int RCS_RATE3_UV_PER_MS = 10_000_000;
    localparam int RCS_STEP_CYC0 = RCS_CLK_HZ / 1000 * RCS_STEP_UV / RCS_RATE0_UV_PER_MS;
    localparam int RCS_STEP_CYC1 = RCS_CLK_HZ / 1000 * RCS_STEP_UV / RCS_RATE1_UV_PER_MS;
    localparam int RCS_STEP_CYC2 = RCS_CLK_HZ / 1000 * RCS_STEP_UV / RCS_RATE2_UV_PER_MS;
    localparam int RCS_STEP_CYC3 = RCS_CLK_HZ / 1000 * RCS_STEP_UV / RCS_RATE3_UV_PER_MS;

    typedef enum logic [1:0] {
        RCS_SLEW_HIGH = 2'b00,
        RCS_SLEW_MED = 2'b01,
        RCS_SLEW_LOW = 2'b10,
        RCS_SLEW_VLOW = 2'b11
    } rcs_slew_t;

    // fault inputs from the analog side
    typedef struct packed {
        logic hot_die_flag;
        logic undervoltage_flag;
        logic overcurrent_flag;
        logic thermal_shutdown_flag;
        logic power_not_good_flag;
    } rcs_faults_t;

    // decoded operating controls
    typedef struct packed {
        rcs_slew_t sda_slew;
        logic quiet_mode;
        logic forced_fixed_freq;
        logic ramped_fixed_freq;
        logic [1:0] voltage_scaling_ramp_rate;
    } rcs_ctrl_t;
endpackage

/* File: design/rcs_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - slew bits 6:5 pick pull-down slew
// - bit 4 enables audible-band avoidance
// - bit 3 forces fixed-frequency operation
// - bit 2 enables ramped fixed-frequency operation
// - bits 1:0 select ramp rate
// - status bit 4 shows hot die
// - status bit 3 shows undervoltage
// - status bit 2 shows overcurrent
// - status bit 1 shows thermal shutdown
// - status bit 0 one means power not good
// - identity upper bits hold maker code
// - identity bits 3:2 major revision
// - identity bits 1:0 minor revision
// - low-select target resets to 3.3 V
// - high-select target resets to 3.45 V
// - code steps 25 mV from 2.025 V
// - reserved bits read zero
// - device answers at address 1110101
module rcs_regs
    import rcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [6:0] bus_dev_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_reg_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_ack,
    input wire logic level_select_pin,
    input wire rcs_pkg::rcs_faults_t faults,
    output rcs_pkg::rcs_ctrl_t ctrl,
    output logic [6:0] level_code
);
    import rcs_pkg::*;

    logic [6:0] ctrl_r;
    logic [6:0] lvl_lo_r;
    logic [6:0] lvl_hi_r;
    logic [4:0] flags_r;
    logic [7:0] rdata_r;
    logic [6:0] level_r;
    logic [19:0] step_cnt_r;
    logic [19:0] step_len;
    logic [6:0] target;
    logic hit;

    // read mux decoding, used only by the bus read path
    function automatic logic [7:0] rcs_read(input logic [7:0] a, input logic [6:0] c,
        input logic [4:0] f, input logic [6:0] lo, input logic [6:0] hi);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            RCS_OFS_CTRL: v = {1'b0, c};
            RCS_OFS_FLAGS: v = {3'b000, f};
            RCS_OFS_IDENT: v = {RCS_MAKER_CODE, RCS_REV_MAJOR, RCS_REV_MINOR};
            RCS_OFS_LVL_LO: v = {1'b0, lo};
            RCS_OFS_LVL_HI: v = {1'b0, hi};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // address match on the serial target
    assign hit = (bus_dev_addr == RCS_TARGET_ADDR);

    // writable registers; bit 7 and read-only offsets are dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= RCS_CTRL_RST;
            lvl_lo_r <= RCS_LVL_LO_RST;
            lvl_hi_r <= RCS_LVL_HI_RST;
        end else if (clk_en && hit && bus_wr) begin
            if (bus_reg_addr == RCS_OFS_CTRL) begin
                ctrl_r <= bus_wdata[6:0];
            end
            if (bus_reg_addr == RCS_OFS_LVL_LO) begin
                lvl_lo_r <= bus_wdata[6:0];
            end
            if (bus_reg_addr == RCS_OFS_LVL_HI) begin
                lvl_hi_r <= bus_wdata[6:0];
            end
        end
    end

    // live fault flags captured each clock-enabled cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= 5'h00;
        end else if (clk_en) begin
            flags_r <= faults;
        end
    end

    // registered read data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else if (clk_en && hit && bus_rd) begin
            rdata_r <= rcs_read(bus_reg_addr, ctrl_r, flags_r, lvl_lo_r, lvl_hi_r);
        end
    end

    assign bus_rdata = rdata_r;
    assign bus_ack = hit && (bus_wr || bus_rd);

    // control field breakout
    assign ctrl.sda_slew = rcs_slew_t'(ctrl_r[RCS_CTRL_SLEW_LSB +: 2]);
    assign ctrl.quiet_mode = ctrl_r[RCS_CTRL_QUIET_BIT];
    assign ctrl.forced_fixed_freq = ctrl_r[RCS_CTRL_FFIX_BIT];
    assign ctrl.ramped_fixed_freq = ctrl_r[RCS_CTRL_RAMPFIX_BIT];
    assign ctrl.voltage_scaling_ramp_rate = ctrl_r[1:0];

    // active target and per-step cycle count
    assign target = level_select_pin ? lvl_hi_r : lvl_lo_r;
    always_comb begin
        unique case (ctrl_r[1:0])
            2'b00: step_len = 20'(RCS_STEP_CYC0);
            2'b01: step_len = 20'(RCS_STEP_CYC1);
            2'b10: step_len = 20'(RCS_STEP_CYC2);
            2'b11: step_len = 20'(RCS_STEP_CYC3);
        endcase
    end

    // ramp the output code one 25 mV step per interval
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_r <= RCS_LVL_LO_RST;
            step_cnt_r <= 20'h00000;
        end else if (clk_en) begin
            if (level_r == target) begin
                step_cnt_r <= 20'h00000;
            end else if (step_cnt_r >= step_len - 20'h00001) begin
                step_cnt_r <= 20'h00000;
                level_r <= (level_r < target) ? level_r + 7'h01 : level_r - 7'h01;
            end else begin
                step_cnt_r <= step_cnt_r + 20'h00001;
            end
        end
    end
    assign level_code = level_r;

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_b) bus_rdata[7] == 1'b0 || $past(bus_reg_addr) == RCS_OFS_IDENT;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_ident;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_rd && bus_reg_addr == RCS_OFS_IDENT
            |=> bus_rdata == {RCS_MAKER_CODE, RCS_REV_MAJOR, RCS_REV_MINOR};
    endproperty
    a_ident: assert property (p_ident) else $error("identity mismatch");

    property p_flags;
        @(posedge clk) disable iff (!rst_b) clk_en |=> flags_r == $past(faults);
    endproperty
    a_flags: assert property (p_flags) else $error("fault flag lost");

    property p_ctrl_wr;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_wr && bus_reg_addr == RCS_OFS_CTRL
            |=> ctrl_r == $past(bus_wdata[6:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write missed");

    property p_ro_ignored;
        @(posedge clk) disable iff (!rst_b) bus_wr && bus_reg_addr != RCS_OFS_CTRL
            |=> $stable(ctrl_r);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("stray control write");

    property p_addr;
        @(posedge clk) disable iff (!rst_b) bus_ack |-> bus_dev_addr == 7'h75;
    endproperty
    a_addr: assert property (p_addr) else $error("ack on wrong address");

    property p_ramp_step;
        @(posedge clk) disable iff (!rst_b) !$stable(level_r) |->
            (level_r == $past(level_r) + 7'h01) || (level_r == $past(level_r) - 7'h01);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp jumped");

    property p_ramp_dir;
        @(posedge clk) disable iff (!rst_b) $past(clk_en) && !$stable(level_r) && $stable(target)
            |-> (level_r > $past(level_r)) == (target > $past(level_r));
    endproperty
    a_ramp_dir: assert property (p_ramp_dir) else $error("ramp wrong way");

    // control fields on the port follow the written byte
    property p_slew_wr;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_wr && bus_reg_addr == RCS_OFS_CTRL
            |=> ctrl.sda_slew == $past(bus_wdata[RCS_CTRL_SLEW_LSB +: 2]);
    endproperty
    a_slew_wr: assert property (p_slew_wr) else $error("slew field wrong");

    property p_quiet_wr;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_wr && bus_reg_addr == RCS_OFS_CTRL
            |=> ctrl.quiet_mode == $past(bus_wdata[RCS_CTRL_QUIET_BIT]);
    endproperty
    a_quiet_wr: assert property (p_quiet_wr) else $error("quiet bit wrong");

    property p_ffix_wr;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_wr && bus_reg_addr == RCS_OFS_CTRL
            |=> ctrl.forced_fixed_freq == $past(bus_wdata[RCS_CTRL_FFIX_BIT]);
    endproperty
    a_ffix_wr: assert property (p_ffix_wr) else $error("forced bit wrong");

    property p_rampfix_wr;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_wr && bus_reg_addr == RCS_OFS_CTRL
            |=> ctrl.ramped_fixed_freq == $past(bus_wdata[RCS_CTRL_RAMPFIX_BIT]);
    endproperty
    a_rampfix_wr: assert property (p_rampfix_wr) else $error("ramped bit wrong");

    property p_rate_wr;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_wr && bus_reg_addr == RCS_OFS_CTRL
            |=> ctrl.voltage_scaling_ramp_rate == $past(bus_wdata[1:0]);
    endproperty
    a_rate_wr: assert property (p_rate_wr) else $error("ramp rate wrong");

    // each status bit tracks its own fault input
    property p_hot_die;
        @(posedge clk) disable iff (!rst_b) clk_en |=> flags_r[4] == $past(faults.hot_die_flag);
    endproperty
    a_hot_die: assert property (p_hot_die) else $error("hot die bit wrong");

    property p_uv;
        @(posedge clk) disable iff (!rst_b) clk_en |=> flags_r[3] == $past(faults.undervoltage_flag);
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage bit wrong");

    property p_oc;
        @(posedge clk) disable iff (!rst_b) clk_en |=> flags_r[2] == $past(faults.overcurrent_flag);
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent bit wrong");

    property p_tsd;
        @(posedge clk) disable iff (!rst_b) clk_en |=> flags_r[1] == $past(faults.thermal_shutdown_flag);
    endproperty
    a_tsd: assert property (p_tsd) else $error("thermal bit wrong");

    property p_png;
        @(posedge clk) disable iff (!rst_b) clk_en |=> flags_r[0] == $past(faults.power_not_good_flag);
    endproperty
    a_png: assert property (p_png) else $error("power bit wrong");

    property p_flags_rd;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_rd && bus_reg_addr == RCS_OFS_FLAGS
            |=> bus_rdata == {3'b000, $past(flags_r)};
    endproperty
    a_flags_rd: assert property (p_flags_rd) else $error("status read wrong");

    // identity and level registers on the read and write paths
    property p_rev_major;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_rd && bus_reg_addr == RCS_OFS_IDENT
            |=> bus_rdata[3:2] == RCS_REV_MAJOR;
    endproperty
    a_rev_major: assert property (p_rev_major) else $error("major revision wrong");

    property p_rev_minor;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_rd && bus_reg_addr == RCS_OFS_IDENT
            |=> bus_rdata[1:0] == RCS_REV_MINOR;
    endproperty
    a_rev_minor: assert property (p_rev_minor) else $error("minor revision wrong");

    property p_lo_wr;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_wr && bus_reg_addr == RCS_OFS_LVL_LO
            |=> lvl_lo_r == $past(bus_wdata[6:0]);
    endproperty
    a_lo_wr: assert property (p_lo_wr) else $error("low target write missed");

    property p_hi_wr;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_wr && bus_reg_addr == RCS_OFS_LVL_HI
            |=> lvl_hi_r == $past(bus_wdata[6:0]);
    endproperty
    a_hi_wr: assert property (p_hi_wr) else $error("high target write missed");

    property p_lvl_top;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_rd
            && (bus_reg_addr == RCS_OFS_LVL_LO || bus_reg_addr == RCS_OFS_LVL_HI) |=> !bus_rdata[7];
    endproperty
    a_lvl_top: assert property (p_lvl_top) else $error("level bit 7 set");

    property p_unmapped;
        @(posedge clk) disable iff (!rst_b) clk_en && hit && bus_rd
            && (bus_reg_addr == 8'h00 || bus_reg_addr > RCS_OFS_LVL_HI) |=> bus_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_ramp_hold;
        @(posedge clk) disable iff (!rst_b) clk_en && level_r == target |=> $stable(level_r);
    endproperty
    a_ramp_hold: assert property (p_ramp_hold) else $error("level moved at target");

    property p_freeze;
        @(posedge clk) disable iff (!rst_b) !clk_en |=> $stable(level_r) && $stable(ctrl_r)
            && $stable(lvl_lo_r) && $stable(lvl_hi_r) && $stable(bus_rdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_lo_ro;
        @(posedge clk) disable iff (!rst_b) bus_wr && bus_reg_addr != RCS_OFS_LVL_LO
            |=> $stable(lvl_lo_r);
    endproperty
    a_lo_ro: assert property (p_lo_ro) else $error("stray low target write");

    property p_hi_ro;
        @(posedge clk) disable iff (!rst_b) bus_wr && bus_reg_addr != RCS_OFS_LVL_HI
            |=> $stable(lvl_hi_r);
    endproperty
    a_hi_ro: assert property (p_hi_ro) else $error("stray high target write");

    property p_ack_strobe;
        @(posedge clk) disable iff (!rst_b) bus_ack |-> bus_wr || bus_rd;
    endproperty
    a_ack_strobe: assert property (p_ack_strobe) else $error("ack without strobe");

    property p_rdata_hold;
        @(posedge clk) disable iff (!rst_b) !(clk_en && hit && bus_rd) |=> $stable(bus_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read byte changed");

    c_ctrl_wr: cover property (@(posedge clk) hit && bus_wr && bus_reg_addr == RCS_OFS_CTRL);
    c_ramp_down: cover property (@(posedge clk) level_r == $past(level_r) - 7'h01);
    c_hot_die: cover property (@(posedge clk) flags_r[4]);
    c_ramp_up: cover property (@(posedge clk) level_r == $past(level_r) + 7'h01);
    c_pin_flip: cover property (@(posedge clk) $rose(level_select_pin));
endmodule

/* File: tb/rcs_host_model.sv */
`timescale 1ns/1ps
// host side of the register port; released address and data lines show the inverse of the last value, strobes drop to zero
module rcs_host_model (
    input wire logic clk,
    output logic [6:0] bus_dev_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic [7:0] bus_reg_addr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_ack
);
    initial begin
        {bus_dev_addr, bus_wr, bus_rd, bus_reg_addr, bus_wdata} = '0;
    end
    // one byte access: request held one edge, ack taken there, read byte after it
    task automatic xfer(input logic [6:0] dev, input logic wr, input logic [7:0] ra,
            input logic [7:0] wd, output logic [7:0] rd, output logic ack);
        @(posedge clk);
        bus_dev_addr <= dev;
        bus_wr <= wr;
        bus_rd <= !wr;
        bus_reg_addr <= ra;
        bus_wdata <= wd;
        @(posedge clk);
        ack = bus_ack;
        bus_dev_addr <= ~dev;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        bus_reg_addr <= ~ra;
        bus_wdata <= ~wd;
        @(posedge clk);
        rd = bus_rdata;
    endtask
endmodule

/* File: tb/rcs_regs_test.sv */
`timescale 1ns/1ps
module rcs_regs_test;
    import rcs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic level_select_pin = 1'b0;
    rcs_faults_t faults = '0;
    logic [6:0] dev;
    logic wr_s, rd_s, ack;
    logic [7:0] ra, wd, rdata;
    rcs_ctrl_t ctrl;
    logic [6:0] level_code;
    int bad_count = 0;
    int n_compared = 0;
    rcs_host_model i_host (.clk(clk), .bus_dev_addr(dev), .bus_wr(wr_s), .bus_rd(rd_s),
        .bus_reg_addr(ra), .bus_wdata(wd), .bus_rdata(rdata), .bus_ack(ack));
    rcs_regs i_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .bus_dev_addr(dev),
        .bus_wr(wr_s), .bus_rd(rd_s), .bus_reg_addr(ra), .bus_wdata(wd), .bus_rdata(rdata),
        .bus_ack(ack), .level_select_pin(level_select_pin), .faults(faults), .ctrl(ctrl),
        .level_code(level_code));
    // clock generator, 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // accesses at the device address, ack expected
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] d;
        logic k;
        i_host.xfer(RCS_TARGET_ADDR, 1'b1, a, v, d, k);
        chk("write ack", 8'h01, {7'h00, k});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic k;
        i_host.xfer(RCS_TARGET_ADDR, 1'b0, a, 8'h00, d, k);
        chk("read ack", 8'h01, {7'h00, k});
        chk($sformatf("reg %h", a), exp, d);
    endtask
    task automatic t_reset();
        rdchk(RCS_OFS_CTRL, 8'h00);
        chk("ctrl port", 8'h00, {1'b0, ctrl});
        rdchk(RCS_OFS_FLAGS, 8'h00);
        rdchk(RCS_OFS_IDENT, {RCS_MAKER_CODE, RCS_REV_MAJOR, RCS_REV_MINOR});
        rdchk(RCS_OFS_LVL_LO, 8'h33);
        rdchk(RCS_OFS_LVL_HI, 8'h39);
        rdchk(8'h00, 8'h00);
        chk("level code", 8'h33, {1'b0, level_code});
    endtask
    // every slew and ramp rate code, reserved bit written as one
    task automatic t_ctrl();
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {1'b1, i[1:0], i[0], i[1], ~i[0], i[1:0]};
            wr(RCS_OFS_CTRL, v);
            rdchk(RCS_OFS_CTRL, {1'b0, v[6:0]});
            chk("ctrl port", {1'b0, v[6:0]}, {1'b0, ctrl});
        end
    endtask
    // each fault alone, then writes to read-only registers
    task automatic t_flags();
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            faults <= rcs_faults_t'(5'h01 << i);
            rdchk(RCS_OFS_FLAGS, 8'h01 << i);
        end
        wr(RCS_OFS_FLAGS, 8'hFF);
        wr(RCS_OFS_IDENT, 8'h00);
        rdchk(RCS_OFS_FLAGS, 8'h10);
        rdchk(RCS_OFS_IDENT, {RCS_MAKER_CODE, RCS_REV_MAJOR, RCS_REV_MINOR});
    endtask
    // foreign address and frozen clock enable leave the target alone
    task automatic t_refuse();
        logic [7:0] d;
        logic k;
        i_host.xfer(7'h74, 1'b1, RCS_OFS_LVL_LO, 8'h10, d, k);
        chk("foreign ack", 8'h00, {7'h00, k});
        @(posedge clk);
        clk_en <= 1'b0;
        i_host.xfer(RCS_TARGET_ADDR, 1'b1, RCS_OFS_LVL_LO, 8'h10, d, k);
        @(posedge clk);
        clk_en <= 1'b1;
        rdchk(RCS_OFS_LVL_LO, 8'h33);
    endtask
    // select high target, ramp 13 codes at the fastest rate
    task automatic t_ramp();
        int n;
        wr(RCS_OFS_LVL_HI, 8'hC0);
        rdchk(RCS_OFS_LVL_HI, 8'h40);
        @(posedge clk);
        level_select_pin <= 1'b1;
        n = 0;
        // sample the settled output away from the launching edge
        while (level_code !== 7'h40 && n < 800) begin
            @(negedge clk);
            n++;
        end
        chk("ramp span", 8'h01,
            {7'h00, n >= 13 * RCS_STEP_CYC3 - 1 && n <= 13 * RCS_STEP_CYC3 + 1});
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_ctrl();
        t_flags();
        t_refuse();
        t_ramp();
        finish_test();
    end
endmodule
